/* rtl/capture_count_reset_map.vh */
// Register map, field positions, reset values and tick divisors for the
// capture/reload timer. Definitions only; included by its bare name.
`ifndef CAPTURE_COUNT_RESET_MAP_VH
`define CAPTURE_COUNT_RESET_MAP_VH

// Register indices; byte address is four times the index
`define CAPTURE_COUNT_RESET_IDX_CONTROL 8'hc8
`define CAPTURE_COUNT_RESET_IDX_MODE 8'hc9
`define CAPTURE_COUNT_RESET_IDX_CAP_LOW 8'hca
`define CAPTURE_COUNT_RESET_IDX_CAP_HIGH 8'hcb
`define CAPTURE_COUNT_RESET_IDX_CNT_LOW 8'hcc
`define CAPTURE_COUNT_RESET_IDX_CNT_HIGH 8'hcd

// Control register fields
`define CAPTURE_COUNT_RESET_CTL_OVF 7
`define CAPTURE_COUNT_RESET_CTL_EXT 6
`define CAPTURE_COUNT_RESET_CTL_RXB 5
`define CAPTURE_COUNT_RESET_CTL_TXB 4
`define CAPTURE_COUNT_RESET_CTL_EXEN 3
`define CAPTURE_COUNT_RESET_CTL_RUN 2
`define CAPTURE_COUNT_RESET_CTL_CT 1
`define CAPTURE_COUNT_RESET_CTL_CPRL 0

// Mode register fields
`define CAPTURE_COUNT_RESET_MOD_HC_LO 4
`define CAPTURE_COUNT_RESET_MOD_CCR 3
`define CAPTURE_COUNT_RESET_MOD_COE 1
`define CAPTURE_COUNT_RESET_MOD_DOWN_COUNT_ENABLE 0
`define CAPTURE_COUNT_RESET_MOD_MASK 8'hfb

// Reset values
`define CAPTURE_COUNT_RESET_RST_CONTROL 8'h00
`define CAPTURE_COUNT_RESET_RST_MODE 8'h00
`define CAPTURE_COUNT_RESET_RST_BYTE 8'h00

// System clocks per internal tick
`define CAPTURE_COUNT_RESET_DIV_SLOW 4'hc
`define CAPTURE_COUNT_RESET_DIV_FAST 4'h4
`define CAPTURE_COUNT_RESET_DIV_BAUD 4'h2

`endif

/* rtl/capture_count_reset_top.v */
// Capture/reload timer with baud generation, clock out and APB registers.
// Assumes pins arrive asynchronously and service-entry strobes come from
// logic on pclk.
//
// Behaviour
// [RULE_01] Overflow flag sets on 16-bit overflow, or on count equal reload when down.
// [RULE_02] Hardware sets overflow flag only with both baud selects clear; software free.
// [RULE_03] Falling trigger edge sets external flag; only software clears it.
// [RULE_04] Software-set or edge-set external flag raises enabled timer interrupt.
// [RULE_05] Receive baud select picks timer one or this timer overflow.
// [RULE_06] Transmit baud select picks timer one or this timer overflow.
// [RULE_07] Baud mode ignores capture select; reloads after every overflow.
// [RULE_08] Baud mode advances every two clocks, regardless of counter select.
// [RULE_09] Trigger ignored when enable clear; edge captures or reloads when set.
// [RULE_10] Clearing run stops the count and keeps it; setting resumes counting.
// [RULE_11] Timer mode counts ticks at selected speed; counter mode counts pin falls.
// [RULE_12] Reload mode loads reload value on overflow and on enabled trigger edge.
// [RULE_13] Capture mode copies count bytes into capture bytes on trigger edge.
// [RULE_14] Capture-reset bit clears the count after each capture.
// [RULE_15] Clock-out enable switches the clock-out function.
// [RULE_16] Down-count enable with trigger level picks direction in auto-reload.
// [RULE_17] Auto-clear bits clear external interrupt two..five flags on service entry.
// [RULE_18] Capture bytes form the 16-bit reload value, low byte least significant.
// [RULE_19] Down counting counts up while trigger high, down while low.
// [RULE_20] Overflow and external flags combine into one gated interrupt request.
`timescale 1ns/1ps
`include "capture_count_reset_map.vh"

module capture_count_reset_top (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Pins, asynchronous
    input wire trigger_pin,
    input wire count_input_pin,
    output reg clock_out_pin,
    output reg clock_out_oe,
    // Neighbouring logic on pclk
    input wire tick_speed_select,
    input wire timer1_overflow,
    input wire serial_mode_13,
    input wire timer_irq_enable,
    input wire [3:0] ext_int_service,
    // Results
    output reg rx_baud_tick,
    output reg tx_baud_tick,
    output reg timer_irq,
    output reg [3:0] ext_int_clear
);

    // Register index hit test, shared by read and write decode
    function hit;
        input [11:0] addr;
        input [7:0] idx;
        begin
            hit = (addr[1:0] == 2'b00) && (addr[11:10] == 2'b00) &&
                (addr[9:2] == idx);
        end
    endfunction

    reg [7:0] ctl_r;
    reg [7:0] ctl_nxt;
    reg [7:0] mod_r;
    reg [15:0] cap_r;
    reg [15:0] cap_nxt;
    reg [15:0] cnt_r;
    reg [15:0] cnt_nxt;
    reg [3:0] presc_r;
    reg [3:0] presc_nxt;
    reg trig_s1_r;
    reg trig_s2_r;
    reg trig_s3_r;
    reg cin_s1_r;
    reg cin_s2_r;
    reg cin_s3_r;
    reg [7:0] rd_byte;
    reg rd_hit;
    reg ovf_evt;
    reg adv;
    reg [3:0] div;
    reg [7:0] wb;

    wire wr_done;
    wire rd_take;
    wire baud_mode;
    wire trig_fall;
    wire cin_fall;
    wire ext_evt;

    assign wr_done = psel && penable && pready && pwrite;
    assign rd_take = psel && penable && !pready;
    assign baud_mode = ctl_r[`CAPTURE_COUNT_RESET_CTL_RXB] | ctl_r[`CAPTURE_COUNT_RESET_CTL_TXB];
    assign trig_fall = trig_s3_r & ~trig_s2_r;
    assign cin_fall = cin_s3_r & ~cin_s2_r;
    // Edge counts only when the external enable is set
    assign ext_evt = trig_fall & ctl_r[`CAPTURE_COUNT_RESET_CTL_EXEN]; // [RULE_09]

    // Two-flop synchronisers; third flop only for edge detection
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trig_s1_r <= 1'b1;
            trig_s2_r <= 1'b1;
            trig_s3_r <= 1'b1;
            cin_s1_r <= 1'b1;
            cin_s2_r <= 1'b1;
            cin_s3_r <= 1'b1;
        end
        else
        begin
            trig_s1_r <= trigger_pin;
            trig_s2_r <= trig_s1_r;
            trig_s3_r <= trig_s2_r;
            cin_s1_r <= count_input_pin;
            cin_s2_r <= cin_s1_r;
            cin_s3_r <= cin_s2_r;
        end
    end

    // Read mux; reserved mode bit reads zero
    always @*
    begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        if (hit(paddr, `CAPTURE_COUNT_RESET_IDX_CONTROL))
            rd_byte = ctl_r;
        else if (hit(paddr, `CAPTURE_COUNT_RESET_IDX_MODE))
            rd_byte = mod_r & `CAPTURE_COUNT_RESET_MOD_MASK;
        else if (hit(paddr, `CAPTURE_COUNT_RESET_IDX_CAP_LOW))
            rd_byte = cap_r[7:0];
        else if (hit(paddr, `CAPTURE_COUNT_RESET_IDX_CAP_HIGH))
            rd_byte = cap_r[15:8];
        else if (hit(paddr, `CAPTURE_COUNT_RESET_IDX_CNT_LOW))
            rd_byte = cnt_r[7:0];
        else if (hit(paddr, `CAPTURE_COUNT_RESET_IDX_CNT_HIGH))
            rd_byte = cnt_r[15:8];
        else
            rd_hit = 1'b0;
    end

    // One wait state: pready rises in the second access cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= rd_take;
            pslverr <= rd_take & ~rd_hit;
            if (rd_take && !pwrite)
                prdata <= {24'h000000, rd_byte};
            else if (!rd_take)
                prdata <= 32'h00000000;
        end
    end

    // Tick prescaler; baud mode forces two clocks per step
    always @*
    begin
        if (baud_mode)
            div = `CAPTURE_COUNT_RESET_DIV_BAUD; // [RULE_08]
        else if (tick_speed_select)
            div = `CAPTURE_COUNT_RESET_DIV_FAST; // [RULE_11]
        else
            div = `CAPTURE_COUNT_RESET_DIV_SLOW;
        adv = 1'b0;
        presc_nxt = presc_r + 4'h1;
        if (presc_r >= div - 4'h1)
        begin
            presc_nxt = 4'h0;
            adv = 1'b1;
        end
        // Counter mode steps on pin falls, except in baud mode
        if (ctl_r[`CAPTURE_COUNT_RESET_CTL_CT] && !baud_mode)
            adv = cin_fall; // [RULE_11]
        // Stopped timer keeps its count
        if (!ctl_r[`CAPTURE_COUNT_RESET_CTL_RUN])
            adv = 1'b0; // [RULE_10]
    end

    // Count, capture and flag next state
    always @*
    begin
        wb = pwdata[7:0];
        ctl_nxt = ctl_r;
        cap_nxt = cap_r;
        cnt_nxt = cnt_r;
        ovf_evt = 1'b0;
        if (adv)
        begin
            if (baud_mode)
            begin
                // Capture select ignored; always reload
                if (cnt_r == 16'hffff)
                begin
                    cnt_nxt = cap_r; // [RULE_07]
                    ovf_evt = 1'b1;
                end
                else
                    cnt_nxt = cnt_r + 16'h0001;
            end
            else if (!ctl_r[`CAPTURE_COUNT_RESET_CTL_CPRL] && mod_r[`CAPTURE_COUNT_RESET_MOD_DOWN_COUNT_ENABLE] &&
                !trig_s2_r)
            begin
                // Down count while trigger low; wrap at reload value
                if (cnt_r == cap_r)
                begin
                    cnt_nxt = 16'hffff; // [RULE_16] [RULE_19]
                    ovf_evt = 1'b1; // [RULE_01]
                end
                else
                    cnt_nxt = cnt_r - 16'h0001; // [RULE_19]
            end
            else if (cnt_r == 16'hffff)
            begin
                ovf_evt = 1'b1; // [RULE_01]
                if (ctl_r[`CAPTURE_COUNT_RESET_CTL_CPRL])
                    cnt_nxt = 16'h0000;
                else
                    cnt_nxt = cap_r; // [RULE_12] [RULE_18]
            end
            else
                cnt_nxt = cnt_r + 16'h0001;
        end
        // Trigger edge captures or reloads only outside baud mode
        if (ext_evt && !baud_mode)
        begin
            if (ctl_r[`CAPTURE_COUNT_RESET_CTL_CPRL])
            begin
                cap_nxt = cnt_r; // [RULE_13]
                if (mod_r[`CAPTURE_COUNT_RESET_MOD_CCR])
                    cnt_nxt = 16'h0000; // [RULE_14]
            end
            else if (!mod_r[`CAPTURE_COUNT_RESET_MOD_DOWN_COUNT_ENABLE])
                cnt_nxt = cap_r; // [RULE_12]
        end
        // Software writes; data writes win over hardware updates
        if (wr_done)
        begin
            if (hit(paddr, `CAPTURE_COUNT_RESET_IDX_CONTROL))
                ctl_nxt = wb; // [RULE_02]
            if (hit(paddr, `CAPTURE_COUNT_RESET_IDX_CAP_LOW))
                cap_nxt[7:0] = wb;
            if (hit(paddr, `CAPTURE_COUNT_RESET_IDX_CAP_HIGH))
                cap_nxt[15:8] = wb;
            if (hit(paddr, `CAPTURE_COUNT_RESET_IDX_CNT_LOW))
                cnt_nxt[7:0] = wb;
            if (hit(paddr, `CAPTURE_COUNT_RESET_IDX_CNT_HIGH))
                cnt_nxt[15:8] = wb;
        end
        // Hardware set wins over a software clear in the same cycle
        if (ovf_evt && !baud_mode)
            ctl_nxt[`CAPTURE_COUNT_RESET_CTL_OVF] = 1'b1; // [RULE_01] [RULE_02]
        if (ext_evt)
            ctl_nxt[`CAPTURE_COUNT_RESET_CTL_EXT] = 1'b1; // [RULE_03]
    end

    // Timer state registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_r <= `CAPTURE_COUNT_RESET_RST_CONTROL;
            mod_r <= `CAPTURE_COUNT_RESET_RST_MODE;
            cap_r <= {`CAPTURE_COUNT_RESET_RST_BYTE, `CAPTURE_COUNT_RESET_RST_BYTE};
            cnt_r <= {`CAPTURE_COUNT_RESET_RST_BYTE, `CAPTURE_COUNT_RESET_RST_BYTE};
            presc_r <= 4'h0;
        end
        else
        begin
            ctl_r <= ctl_nxt;
            cap_r <= cap_nxt;
            cnt_r <= cnt_nxt;
            presc_r <= presc_nxt;
            if (wr_done && hit(paddr, `CAPTURE_COUNT_RESET_IDX_MODE))
                mod_r <= pwdata[7:0] & `CAPTURE_COUNT_RESET_MOD_MASK;
        end
    end

    // Baud ticks, clock out and interrupt, all registered
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_baud_tick <= 1'b0;
            tx_baud_tick <= 1'b0;
            clock_out_pin <= 1'b0;
            clock_out_oe <= 1'b0;
            timer_irq <= 1'b0;
        end
        else
        begin
            rx_baud_tick <= serial_mode_13 & (ctl_r[`CAPTURE_COUNT_RESET_CTL_RXB] ?
                ovf_evt : timer1_overflow); // [RULE_05]
            tx_baud_tick <= serial_mode_13 & (ctl_r[`CAPTURE_COUNT_RESET_CTL_TXB] ?
                ovf_evt : timer1_overflow); // [RULE_06]
            // Clock out toggles per overflow, so it runs at half that rate
            clock_out_oe <= mod_r[`CAPTURE_COUNT_RESET_MOD_COE]; // [RULE_15]
            if (!mod_r[`CAPTURE_COUNT_RESET_MOD_COE])
                clock_out_pin <= 1'b0;
            else if (ovf_evt)
                clock_out_pin <= ~clock_out_pin; // [RULE_15]
            // Software-set external flag requests too, as it is one register
            timer_irq <= timer_irq_enable &
                (ctl_r[`CAPTURE_COUNT_RESET_CTL_OVF] | ctl_r[`CAPTURE_COUNT_RESET_CTL_EXT]); // [RULE_04] [RULE_20]
        end
    end

    // Auto-clear strobes for external interrupts two to five
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_hc
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    ext_int_clear[gi] <= 1'b0;
                else
                    ext_int_clear[gi] <= mod_r[`CAPTURE_COUNT_RESET_MOD_HC_LO + gi] &
                        ext_int_service[gi]; // [RULE_17]
            end
        end
    endgenerate

endmodule // capture_count_reset_top

/* verif/capture_count_reset_pins.sv */
// Far-side model of the trigger and count input pins.
// Assumes the bench calls pulse right after a rising clock edge.
`timescale 1ns/1ps
module capture_count_reset_pins (
    // Clock
    input wire pclk,
    // Pins, idle high
    output logic trigger_pin,
    output logic count_input_pin
);
    // Idle high, so the synchronisers see no false fall
    initial
    begin
        trigger_pin = 1'b1;
        count_input_pin = 1'b1;
    end

    // One falling edge; len sets a prompt or slow pulse
    task automatic pulse(input bit trig, input int len);
        @(posedge pclk);
        if (trig)
            trigger_pin <= 1'b0;
        else
            count_input_pin <= 1'b0;
        repeat (len) @(posedge pclk);
        trigger_pin <= 1'b1;
        count_input_pin <= 1'b1;
        repeat (len) @(posedge pclk);
    endtask
endmodule // capture_count_reset_pins

/* verif/capture_count_reset_top_sva.sv */
// Assertions on the timer's APB and side-band outputs.
// Bound to capture_count_reset_top; one clock domain.
`timescale 1ns/1ps
module capture_count_reset_top_sva (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Side band
    input wire clock_out_pin,
    input wire clock_out_oe,
    input wire serial_mode_13,
    input wire timer_irq_enable,
    input wire [3:0] ext_int_service,
    input wire rx_baud_tick,
    input wire tx_baud_tick,
    input wire timer_irq,
    input wire [3:0] ext_int_clear
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    wait_state_a: assert property (psel && $rose(penable) |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 0)
        else $error("prdata not zero");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    irq_gate_a: assert property (timer_irq |-> $past(timer_irq_enable))
        else $error("irq while disabled");
    clear_cause_a: assert property (ext_int_clear != 4'h0 |->
        (ext_int_clear & ~$past(ext_int_service)) == 4'h0)
        else $error("clear without service");
    clkout_off_a: assert property (!clock_out_oe &&
        !$past(clock_out_oe) |-> !clock_out_pin)
        else $error("clock out while off");
    rx_gate_a: assert property (rx_baud_tick |-> $past(serial_mode_13))
        else $error("rx tick outside mode");
    tx_gate_a: assert property (tx_baud_tick |-> $past(serial_mode_13))
        else $error("tx tick outside mode");
    baud_gap_a: assert property (tx_baud_tick |=> !tx_baud_tick)
        else $error("baud ticks adjacent");
endmodule // capture_count_reset_top_sva

bind capture_count_reset_top capture_count_reset_top_sva u_sva (.pclk, .presetn, .psel, .penable,
    .pwrite, .prdata, .pready, .pslverr, .clock_out_pin, .clock_out_oe,
    .serial_mode_13, .timer_irq_enable, .ext_int_service, .rx_baud_tick,
    .tx_baud_tick, .timer_irq, .ext_int_clear);

/* verif/capture_count_reset_top_bench.sv */
// Self-checking bench for the capture/reload timer over APB.
// Assumes capture_count_reset_top, capture_count_reset_pins and the bound checker are compiled.
`timescale 1ns/1ps
`include "capture_count_reset_map.vh"
`define CK(n, e, a) begin checks++; if ((a) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module capture_count_reset_top_bench;
    localparam bit [7:0] CT = `CAPTURE_COUNT_RESET_IDX_CONTROL, MD = `CAPTURE_COUNT_RESET_IDX_MODE;
    localparam bit [7:0] CL = `CAPTURE_COUNT_RESET_IDX_CAP_LOW, CH = `CAPTURE_COUNT_RESET_IDX_CAP_HIGH;
    localparam bit [7:0] NL = `CAPTURE_COUNT_RESET_IDX_CNT_LOW, NH = `CAPTURE_COUNT_RESET_IDX_CNT_HIGH;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic trigger_pin, count_input_pin, clock_out_pin, clock_out_oe;
    logic tick_speed_select, timer1_overflow, serial_mode_13;
    logic timer_irq_enable, rx_baud_tick, tx_baud_tick, timer_irq;
    logic [3:0] ext_int_service, ext_int_clear, acc;
    logic [7:0] rv, v;
    int checks, mismatches, cyc, nt, nr;

    capture_count_reset_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .trigger_pin, .count_input_pin,
        .clock_out_pin, .clock_out_oe, .tick_speed_select, .timer1_overflow,
        .serial_mode_13, .timer_irq_enable, .ext_int_service, .rx_baud_tick,
        .tx_baud_tick, .timer_irq, .ext_int_clear);
    capture_count_reset_pins pins (.pclk, .trigger_pin, .count_input_pin);

    // Free-running 100 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Hang guard, well above the expected run length
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            conclude();
        end
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One APB transfer; ends one idle cycle after completion
    task automatic apb(input bit wr, input [7:0] idx, input [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Sample mid-cycle, where pready and prdata have settled
        @(negedge pclk);
        while (pready !== 1'b1) @(negedge pclk);
        rv = prdata[7:0];
        se = pslverr;
        // Release only after the edge that completes the transfer
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input [7:0] idx, input [7:0] e, input string n);
        apb(1'b0, idx, 8'h00);
        `CK(n, e, rv)
    endtask

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {tick_speed_select, timer1_overflow, serial_mode_13} = '0;
        timer_irq_enable = 1'b1;
        ext_int_service = 4'h0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, then an unmapped word
        for (int i = 0; i < 6; i++) rd(8'(CT + i), 8'h00, "reset");
        apb(1'b0, 8'h00, 8'h00);
        `CK("slverr", 1'b1, se)
        // Reserved mode bit, auto-clear pulses, clock-out enable
        apb(1'b1, MD, 8'hff);
        rd(MD, 8'hfb, "mode");
        `CK("oe", 1'b1, clock_out_oe)
        ext_int_service <= 4'h5;
        @(posedge pclk);
        ext_int_service <= 4'h0;
        acc = 4'h0;
        repeat (3) @(negedge pclk) acc |= ext_int_clear;
        @(posedge pclk);
        `CK("eclr", 4'h5, acc)
        $display("mode test done");
        // Capture with count reset; trigger ignored while disabled
        apb(1'b1, MD, 8'h08);
        apb(1'b1, NL, 8'h78);
        apb(1'b1, NH, 8'h56);
        apb(1'b1, CT, 8'h01);
        pins.pulse(1'b1, 4);
        rd(CT, 8'h01, "noedge");
        apb(1'b1, CT, 8'h09);
        pins.pulse(1'b1, 2);
        rd(CL, 8'h78, "caplo");
        rd(CH, 8'h56, "caphi");
        rd(NL, 8'h00, "cntrst");
        rd(CT, 8'h49, "extflag");
        `CK("irq", 1'b1, timer_irq)
        apb(1'b1, CT, 8'h00);
        rd(CT, 8'h00, "swclr");
        apb(1'b1, CT, 8'h40);
        @(posedge pclk);
        `CK("swirq", 1'b1, timer_irq)
        $display("capture test done");
        // Auto-reload from overflow, then stop and hold
        apb(1'b1, CL, 8'h34);
        apb(1'b1, CH, 8'h12);
        apb(1'b1, NL, 8'hfe);
        apb(1'b1, NH, 8'hff);
        tick_speed_select <= 1'b1;
        apb(1'b1, CT, 8'h04);
        repeat (12) @(posedge pclk);
        rd(CT, 8'h84, "ovf");
        apb(1'b1, CT, 8'h80);
        rd(NH, 8'h12, "reload");
        apb(1'b0, NL, 8'h00);
        v = rv;
        repeat (30) @(posedge pclk);
        rd(NL, v, "held");
        $display("reload test done");
        // Counter mode counts pin falls only
        apb(1'b1, CT, 8'h00);
        apb(1'b1, NL, 8'h00);
        apb(1'b1, NH, 8'h00);
        apb(1'b1, CT, 8'h06);
        repeat (3) pins.pulse(1'b0, 3);
        apb(1'b1, CT, 8'h00);
        rd(NL, 8'h03, "counter");
        $display("counter test done");
        // Baud mode: two clocks a tick, reload, capture select ignored
        serial_mode_13 <= 1'b1;
        apb(1'b1, CL, 8'hf0);
        apb(1'b1, CH, 8'hff);
        apb(1'b1, NL, 8'hf0);
        apb(1'b1, NH, 8'hff);
        apb(1'b1, CT, 8'h35);
        nt = 0;
        nr = 0;
        repeat (320)
        begin
            @(posedge pclk);
            nt += int'(tx_baud_tick === 1'b1);
            nr += int'(rx_baud_tick === 1'b1);
        end
        `CK("txn", 1'b1, nt >= 9 && nt <= 11)
        `CK("rxn", nt, nr)
        apb(1'b1, CT, 8'h31);
        rd(CT, 8'h31, "noovf");
        rd(NH, 8'hff, "baudrl");
        $display("baud test done");
        conclude();
    end
endmodule // capture_count_reset_top_bench
